// ==== design/nvp_defines.svh ====
// constants for the nonvolatile potentiometer serial target port
`ifndef NVP_DEFINES_SVH
`define NVP_DEFINES_SVH
`define NVP_CLK_PERIOD_NS 10
`define NVP_NV_WRITE_TIME_US 10
`define NVP_ADDR_FIXED 5'h0A
`define NVP_LOC_WIPER 8'h00
`define NVP_LOC_CTRL 8'h02
`define NVP_CTRL_RESET 8'h00
`define NVP_PUV_RESET 8'h40
`define NVP_MODE_BIT 7
`define NVP_BYTE_LAST 4'h8
`define NVP_BIT_ACK 4'h9
`endif

// ==== design/nvp_pkg.sv ====
// types shared by the potentiometer serial target port
`default_nettype none
package nvp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_LOC, ST_DATA, ST_TX, ST_IGN
  } nvp_state_t;
  typedef struct packed {
    logic [7:0] loc;
    logic [7:0] data;
    logic wiper_only;
  } nvp_wr_t;
endpackage
`default_nettype wire

// ==== design/nvp_target.sv ====
// serial target port with write fifo, wiper and power-up value storage
`include "nvp_defines.svh"
`default_nettype none

module nvp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_i,              // system clock
  input wire logic reset_n_i,           // async reset, active low
  input wire logic in_valid_i,          // write side valid
  output logic in_ready_o,              // write side ready
  input wire logic [WIDTH-1:0] in_data_i, // write data
  output logic out_valid_o,             // read side valid
  input wire logic out_ready_i,         // read side ready
  output logic [WIDTH-1:0] out_data_o   // read data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_o = wr_ptr != rd_ptr;
  assign out_data_o = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

module nvp_target import nvp_pkg::*; #(
  parameter int NV_WRITE_CYC =
    `NVP_NV_WRITE_TIME_US * 1000 / `NVP_CLK_PERIOD_NS,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic mclk_i,            // 100 MHz clock
  input wire logic reset_n_i,         // async reset, active low
  input wire logic scl_i,             // bus clock pin
  input wire logic sda_i,             // bus data pin level
  output logic sda_o,                 // data drive level, always low
  output logic sda_oe_o,              // data pull-down enable
  input wire logic addr_select_lo_i,  // address select pin, low bit
  input wire logic addr_select_hi_i,  // address select pin, high bit
  output logic [6:0] wiper_o,         // wiper position
  output logic nv_busy_o              // nonvolatile write in progress
);
  logic [1:0] scl_sync, sda_sync, asl_sync, ash_sync;
  logic scl_d, sda_d;
  nvp_state_t st;
  logic [3:0] cnt;
  logic [7:0] rx_sh, tx_sh, mem_ptr, control_reg, power_up_value_reg;
  logic [7:0] ivr_stage;
  logic rw, mack, nv_pend, recall_done;
  logic [31:0] nv_cnt;
  logic [6:0] wiper;
  nvp_wr_t fifo_in, fifo_out;
  logic fifo_in_ready, fifo_out_valid;

  // pins pass two flops; edge logic compares the second stage with its one-cycle delayed copy
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      asl_sync <= 2'h0;
      ash_sync <= 2'h0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_i};
      sda_sync <= {sda_sync[0], sda_i};
      asl_sync <= {asl_sync[0], addr_select_lo_i};
      ash_sync <= {ash_sync[0], addr_select_hi_i};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
    end
  end

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire start_det = scl_s && scl_d && sda_d && !sda_s;
  wire stop_det = scl_s && scl_d && !sda_d && sda_s;
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire [6:0] my_addr = {`NVP_ADDR_FIXED, ash_sync[1], asl_sync[1]};
  wire addr_hit = rx_sh[7:1] == my_addr && !nv_busy_o;
  wire byte_end = scl_fall && cnt == `NVP_BYTE_LAST;
  wire ack_end = scl_fall && cnt == `NVP_BIT_ACK;
  wire mode1 = control_reg[`NVP_MODE_BIT];
  wire data_push = byte_end && st == ST_DATA && fifo_in_ready;
  wire nv_hit = mem_ptr == `NVP_LOC_WIPER && !mode1;
  // read data always from the counter, never from the read request
  wire [7:0] rd_data = mem_ptr == `NVP_LOC_WIPER ? {1'b0, wiper} :
                       mem_ptr == `NVP_LOC_CTRL ? control_reg : 8'h00;
  wire apply = fifo_out_valid && !nv_busy_o;

  assign sda_o = 1'b0;
  assign wiper_o = wiper;
  assign nv_busy_o = nv_cnt != 32'h0;
  assign fifo_in = '{loc: mem_ptr, data: rx_sh, wiper_only: mode1};

  // bit-level receive: shift on rising clock, msb first
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt <= 4'h0;
      rx_sh <= 8'h00;
      mack <= 1'b1;
    end else if (start_det || stop_det || ack_end) begin
      cnt <= 4'h0;
    end else if (scl_rise) begin
      if (cnt < `NVP_BYTE_LAST) rx_sh <= {rx_sh[6:0], sda_s};
      else mack <= sda_s;
      cnt <= cnt + 4'h1;
    end
  end

  // byte-level sequencing and the pull-down
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= ST_IDLE;
      sda_oe_o <= 1'b0;
      rw <= 1'b0;
      mem_ptr <= 8'h00;
      tx_sh <= 8'h00;
    end else if (start_det) begin
      st <= ST_ADDR;
      sda_oe_o <= 1'b0;
    end else if (stop_det) begin
      st <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (byte_end) begin
      unique case (st)
        ST_ADDR: begin
          sda_oe_o <= addr_hit;
          rw <= rx_sh[0];
          if (!addr_hit) st <= ST_IGN;
        end
        ST_LOC: begin
          mem_ptr <= rx_sh;
          sda_oe_o <= 1'b1;
        end
        ST_DATA: sda_oe_o <= fifo_in_ready; // full fifo answers nack
        ST_TX: sda_oe_o <= 1'b0;         // controller owns the ninth bit
        ST_IDLE, ST_IGN: sda_oe_o <= 1'b0;
      endcase
    end else if (ack_end) begin
      sda_oe_o <= 1'b0;
      unique case (st)
        ST_ADDR: begin
          st <= rw ? ST_TX : ST_LOC;
          if (rw) begin
            sda_oe_o <= !rd_data[7];
            tx_sh <= {rd_data[6:0], 1'b0};
          end
        end
        ST_LOC: st <= ST_DATA;
        ST_DATA: if (!sda_oe_o) st <= ST_IGN;
        ST_TX: begin
          if (mack) begin
            st <= ST_IGN;
          end else begin
            sda_oe_o <= !rd_data[7];
            tx_sh <= {rd_data[6:0], 1'b0};
          end
        end
        ST_IDLE, ST_IGN: st <= st;
      endcase
    end else if (scl_fall && st == ST_TX && cnt < `NVP_BYTE_LAST) begin
      sda_oe_o <= !tx_sh[7];
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // the address is nacked while programming runs; accepted writes queue here
  nvp_fifo #(.WIDTH($bits(nvp_wr_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(data_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(apply),
    .out_data_o(fifo_out)
  );

  // nonvolatile programming: armed at data ack, launched only by stop
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nv_pend <= 1'b0;
      nv_cnt <= 32'h0;
    end else begin
      // a repeated start drops the pending write; the wiper change stays
      if (start_det) nv_pend <= 1'b0;
      else if (stop_det && nv_pend) nv_pend <= 1'b0;
      else if (data_push && nv_hit) nv_pend <= 1'b1;
      if (stop_det && nv_pend) nv_cnt <= 32'(NV_WRITE_CYC);
      else if (nv_busy_o) nv_cnt <= nv_cnt - 32'h1;
    end
  end

  // register update; the stored value only lands when programming ends
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      control_reg <= `NVP_CTRL_RESET;
      power_up_value_reg <= `NVP_PUV_RESET;
      ivr_stage <= `NVP_PUV_RESET;
      wiper <= 7'(`NVP_PUV_RESET);
      recall_done <= 1'b0;
    end else begin
      recall_done <= 1'b1;
      if (!recall_done) begin
        wiper <= power_up_value_reg[6:0];
      end else if (apply && fifo_out.loc == `NVP_LOC_WIPER) begin
        wiper <= fifo_out.data[6:0];
        if (!fifo_out.wiper_only) ivr_stage <= fifo_out.data;
      end else if (apply && fifo_out.loc == `NVP_LOC_CTRL) begin
        control_reg <= fifo_out.data;
      end
      if (nv_cnt == 32'h1) power_up_value_reg <= ivr_stage;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_addr_byte_done;
    byte_end && st == ST_ADDR;
  endsequence

  chk_start_to_addr: assert property (
    start_det |=> st == ST_ADDR && cnt == 4'h0 && !sda_oe_o)
    else $error("start did not restart the address byte");
  chk_stop_to_idle: assert property (
    stop_det |=> st == ST_IDLE && !sda_oe_o)
    else $error("stop did not end the transfer");
  chk_oe_on_fall: assert property (
    $changed(sda_oe_o) |-> $past(scl_fall || start_det || stop_det))
    else $error("data drive changed outside a falling clock");
  chk_addr_busy_nack: assert property (
    s_addr_byte_done and nv_busy_o |=> !sda_oe_o ##1 st == ST_IGN)
    else $error("address acknowledged during nonvolatile write");
  chk_addr_match_ack: assert property (
    s_addr_byte_done and addr_hit |=> sda_oe_o && st == ST_ADDR)
    else $error("own address not acknowledged");
  chk_ignore_hold: assert property (
    st == ST_IGN && !start_det && !stop_det |=> st == ST_IGN && !sda_oe_o)
    else $error("ignored transfer touched the bus");
  chk_nv_after_stop: assert property (
    stop_det && nv_pend |=> nv_busy_o ##1 nv_busy_o)
    else $error("nonvolatile write not launched by stop");
  chk_rstart_skip: assert property (
    start_det && !nv_busy_o |=> !nv_pend && !nv_busy_o)
    else $error("repeated start left a nonvolatile write");
  chk_mode1_no_nv: assert property (
    data_push && mode1 && !nv_pend |=> !nv_pend)
    else $error("mode one write armed nonvolatile write");
  chk_drive_low: assert property (
    sda_o == 1'b0)
    else $error("data line driven high");

  // empty fifo, so its head is the byte just taken
  sequence s_wiper_taken;
    data_push && !fifo_out_valid && !nv_busy_o &&
      mem_ptr == `NVP_LOC_WIPER;
  endsequence

  sequence s_tx_bit_fall;
    scl_fall && st == ST_TX && cnt < `NVP_BYTE_LAST;
  endsequence

  sequence s_rx_bit_rise;
    scl_rise && cnt < `NVP_BYTE_LAST;
  endsequence

  sequence s_ctrl_ack_end;
    ack_end && (st == ST_LOC || st == ST_DATA);
  endsequence

  chk_wiper_on_ack: assert property (
    s_wiper_taken |-> ##2 wiper == $past(rx_sh[6:0], 2))
    else $error("wiper not updated after data acknowledge");
  chk_nv_commit: assert property (
    nv_cnt == 32'h1 |=> power_up_value_reg == $past(ivr_stage))
    else $error("power-up value not stored at end of programming");
  chk_ptr_hold: assert property (
    !(byte_end && st == ST_LOC) |=> $stable(mem_ptr))
    else $error("address counter moved without a new location");
  chk_ack_release: assert property (
    s_ctrl_ack_end |=> !sda_oe_o)
    else $error("acknowledge held past the ninth bit");
  chk_tx_bit: assert property (
    s_tx_bit_fall |=> sda_oe_o == !$past(tx_sh[7]))
    else $error("read bit not driven after falling clock");
  chk_read_counter: assert property (
    ack_end && st == ST_ADDR && rw |=> sda_oe_o == !$past(rd_data[7]))
    else $error("read did not start from the address counter");
  chk_rx_msb_first: assert property (
    s_rx_bit_rise |=> rx_sh == {$past(rx_sh[6:0]), $past(sda_s)})
    else $error("received bit not shifted in msb first");
  chk_addr_miss_ign: assert property (
    s_addr_byte_done and !addr_hit |=> st == ST_IGN && !sda_oe_o)
    else $error("foreign address not ignored");
  chk_busy_holds: assert property (
    nv_busy_o |-> !apply)
    else $error("register update during nonvolatile write");
endmodule
`default_nettype wire

// ==== test/nvp_ctrl_model.sv ====
// bus controller model: makes the bus clock and drives data open drain
`default_nettype none
module nvp_ctrl_model (
  input wire logic mclk_i,     // system clock
  input wire logic sda_i,      // resolved data wire
  output logic scl_o,          // bus clock, pushed by the controller
  output logic sda_low_o       // high pulls the data wire low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // data moves only mid clock-low; sampled late in clock high
  task automatic bit_io(input logic b, output logic r);
    tick(4);
    sda_low_o = !b;
    tick(4);
    scl_o = 1'b1;
    tick(6);
    r = sda_i;
    tick(2);
    scl_o = 1'b0;
  endtask
  // also serves as repeated start from clock low
  task automatic start();
    tick(2); // hold data past the last falling clock
    sda_low_o = 1'b0;
    tick(2);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = 1'b1;
    tick(8);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_low_o = 1'b1;
    tick(2);
    scl_o = 1'b1;
    tick(8);
    sda_low_o = 1'b0;
    tick(8);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, ack);
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// ==== test/nvp_target_test.sv ====
// self-checking bench for the potentiometer serial target port
`default_nettype none
module nvp_target_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NVC = 400;
  logic mclk, reset_n, sel_lo, sel_hi, sda_oe, sda_drv, busy, scl, ctl_low;
  logic [6:0] wiper;
  logic a;
  logic [7:0] d;
  wire logic sda_w;
  int bad_count = 0;
  int tests_run = 0;
  int cyc = 0;
  assign sda_w = !(ctl_low || (sda_oe && !sda_drv));
  nvp_target #(.NV_WRITE_CYC(NVC)) i_nvp_target (
    .mclk_i(mclk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .addr_select_lo_i(sel_lo),
    .addr_select_hi_i(sel_hi), .wiper_o(wiper), .nv_busy_o(busy));
  nvp_ctrl_model i_nvp_ctrl_model (
    .mclk_i(mclk), .sda_i(sda_w), .scl_o(scl), .sda_low_o(ctl_low));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = !mclk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] b);
    i_nvp_ctrl_model.wr_byte(b, a);
    check({7'h00, a}, 8'h00);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < NVC + 50 && busy !== 1'b0; i++) @(negedge mclk);
    check({7'h00, busy}, 8'h00);
  endtask
  task automatic wr(input logic [7:0] loc, input logic [7:0] v);
    i_nvp_ctrl_model.start();
    put(8'h50);
    put(loc);
    put(v);
    i_nvp_ctrl_model.stop();
  endtask
  task automatic rd_loc(input logic [7:0] loc, input logic [7:0] exp);
    i_nvp_ctrl_model.start();
    put(8'h50);
    put(loc);
    i_nvp_ctrl_model.start();
    put(8'h51);
    i_nvp_ctrl_model.rd_byte(1'b1, d);
    check(d, exp);
    i_nvp_ctrl_model.stop();
  endtask
  task automatic s_nv_write();
    i_nvp_ctrl_model.start();
    put(8'h50);
    put(8'h00);
    put(8'h25);
    i_nvp_ctrl_model.tick(4);
    check({1'b0, wiper}, 8'h25);
    check({7'h00, busy}, 8'h00);
    i_nvp_ctrl_model.stop();
    i_nvp_ctrl_model.tick(2);
    check({7'h00, busy}, 8'h01);
    i_nvp_ctrl_model.start();
    i_nvp_ctrl_model.wr_byte(8'h50, a);
    check({7'h00, a}, 8'h01);
    for (int i = 0; i < 8 && a !== 1'b0; i++) begin
      i_nvp_ctrl_model.stop();
      i_nvp_ctrl_model.start();
      i_nvp_ctrl_model.wr_byte(8'h50, a);
    end
    check({7'h00, a}, 8'h00);
    i_nvp_ctrl_model.stop();
    rd_loc(8'h00, 8'h25);
  endtask
  task automatic s_rep_start();
    i_nvp_ctrl_model.start();
    put(8'h50);
    put(8'h00);
    put(8'h33);
    i_nvp_ctrl_model.start();
    put(8'h51);
    i_nvp_ctrl_model.rd_byte(1'b1, d);
    check(d, 8'h33);
    i_nvp_ctrl_model.stop();
    i_nvp_ctrl_model.tick(4);
    check({7'h00, busy}, 8'h00);
  endtask
  task automatic s_mode_one();
    wr(8'h02, 8'h80);
    wait_idle();
    wr(8'h00, 8'h11);
    i_nvp_ctrl_model.tick(4);
    check({7'h00, busy}, 8'h00);
    check({1'b0, wiper}, 8'h11);
    rd_loc(8'h02, 8'h80);
    // plain read with no location: counter still holds 02h
    i_nvp_ctrl_model.start();
    put(8'h51);
    i_nvp_ctrl_model.rd_byte(1'b1, d);
    check(d, 8'h80);
    i_nvp_ctrl_model.stop();
    wr(8'h02, 8'h00);
    wait_idle();
  endtask
  task automatic s_wrong_addr();
    sel_lo = 1'b1;
    i_nvp_ctrl_model.tick(4);
    i_nvp_ctrl_model.start();
    i_nvp_ctrl_model.wr_byte(8'h50, a);
    check({7'h00, a}, 8'h01);
    i_nvp_ctrl_model.wr_byte(8'h00, a);
    check({7'h00, a}, 8'h01);
    i_nvp_ctrl_model.wr_byte(8'h77, a);
    i_nvp_ctrl_model.stop();
    check({1'b0, wiper}, 8'h11);
    i_nvp_ctrl_model.start();
    put(8'h52);
    put(8'h00);
    put(8'h66);
    i_nvp_ctrl_model.stop();
    wait_idle();
    check({1'b0, wiper}, 8'h66);
    sel_lo = 1'b0;
    sel_hi = 1'b1;
    i_nvp_ctrl_model.tick(4);
    i_nvp_ctrl_model.start();
    i_nvp_ctrl_model.wr_byte(8'h52, a);
    check({7'h00, a}, 8'h01);
    i_nvp_ctrl_model.stop();
    i_nvp_ctrl_model.start();
    put(8'h54);
    put(8'h00);
    i_nvp_ctrl_model.start();
    put(8'h55);
    i_nvp_ctrl_model.rd_byte(1'b1, d);
    check(d, 8'h66);
    i_nvp_ctrl_model.stop();
  endtask
  initial begin
    reset_n = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    repeat (4) @(negedge mclk);
    check({1'b0, wiper}, 8'h40);
    check({7'h00, busy}, 8'h00);
    rd_loc(8'h02, 8'h00);
    s_nv_write();
    s_rep_start();
    s_mode_one();
    s_wrong_addr();
    close_out();
  end
endmodule
`default_nettype wire
